// ===== design/sdc_config_top.sv
// Divider configuration logic of a reference-locked frequency synthesizer:
// parallel and serial loading, reference/feedback/output dividers, phase
// comparison and the test monitor selector.
// Assumes every pin, the serial clock and oscillator levels included, is
// synchronous to clk and changes slower than clk.
//
// Summary of operation
// [R1] Selected reference is divided by sixteen before phase comparison.
// [R2] Loop drives oscillator to twice the feedback value times divided ref.
// [R3] Output divider gives equal high and low time for every setting.
// [R4] Parallel strobe low: divider pins pass straight to the dividers.
// [R5] Parallel strobe rising: values latched until it falls or serial load.
// [R6] Tied divider pins give default settings at power-up via pass-through.
// [R7] Monitor output is low in parallel load mode.
// [R8] Host programs feedback values 100 to 350 with sixteen megahertz ref.
// [R9] Synthesized output is oscillator divided by the selected output ratio.
// [R10] Serial mode shifts one data bit per rising serial clock.
// [R11] Transfer strobe rising copies shift register into the dividers.
// [R12] Transfer strobe falling latches and holds the divider values.
// [R13] Transfer strobe high: serial data flows into dividers per clock.
// [R14] Serial word also carries two test-select bits held internally.
// [R15] Select 00 low, 01 serial data, 10 feedback out, 11 synth out.
// [R16] Divider reset clears dividers and outputs, keeps loaded values.
// [R17] Reference select high picks crystal, low picks auxiliary clock.
// [R18] Serial mode idle: parallel pins cannot alter loaded values.
// [R19] Fourteen-bit word: select, output code, feedback, MSB first.
// [R20] Latest completed load from either path sets active values.
`timescale 1ns/1ns
module sdc_config_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Parallel load pins
	input wire logic parallel_strobe_n,
	input wire logic [sdc_pkg::SDC_M_W-1:0] feedback_divider_pins,
	input wire logic [sdc_pkg::SDC_N_W-1:0] output_divider_pins,
	// Serial load pins
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic serial_load,
	// Reference and oscillator levels
	input wire logic ref_source_select,
	input wire logic ref_xtal_in,
	input wire logic ref_aux_in,
	input wire logic osc_in,
	input wire logic divider_reset_in,
	// Loop control
	output logic pump_up,
	output logic pump_dn,
	output logic ref_div_out,
	output logic fb_div_out,
	// Synthesized outputs
	output logic synth_out_a,
	output logic synth_out_a_n,
	output logic synth_out_b,
	output logic synth_out_b_n,
	// Status
	output logic test_monitor,
	output sdc_pkg::sdc_cfg_t active_cfg,
	output sdc_pkg::sdc_mode_t load_mode,
	output logic lock_range_ok
);
	import sdc_pkg::*;

	// ********************************************************
	// Input edge detection
	// ********************************************************
	logic sclk_prev_q;
	logic sload_prev_q;
	logic ref_prev_q;
	logic osc_prev_q;
	logic sclk_rise;
	logic sload_rise;
	logic ref_sel;
	logic ref_tick;
	logic osc_tick;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			sload_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= serial_clock;
			sload_prev_q <= serial_load;
			ref_prev_q <= ref_sel;
			osc_prev_q <= osc_in;
		end
	end

	assign sclk_rise = serial_clock & ~sclk_prev_q;
	assign sload_rise = serial_load & ~sload_prev_q;
	assign ref_sel = ref_source_select ? ref_xtal_in : ref_aux_in; // [R17]
	assign ref_tick = ref_sel & ~ref_prev_q;
	assign osc_tick = osc_in & ~osc_prev_q;

	// ********************************************************
	// Load mode
	// ********************************************************
	sdc_mode_t mode_d;
	sdc_mode_t mode_q;

	always_comb begin
		if (!parallel_strobe_n) begin
			mode_d = SDC_MODE_PAR;
		end else if (serial_load) begin
			mode_d = SDC_MODE_XFER;
		end else begin
			mode_d = SDC_MODE_SHIFT;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= SDC_MODE_PAR;
		end else begin
			mode_q <= mode_d;
		end
	end

	assign load_mode = mode_q;

	// ********************************************************
	// Serial shift register
	// ********************************************************
	sdc_cfg_t shift_q;
	sdc_cfg_t shift_d;

	// First bit shifted lands in the top select bit after fourteen clocks
	assign shift_d = {shift_q[SDC_CFG_W-2:0], serial_data}; // [R19]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= SDC_CFG_RST;
		end else if (parallel_strobe_n && sclk_rise) begin
			shift_q <= shift_d; // [R10]
		end
	end

	// ********************************************************
	// Active divider values
	// ********************************************************
	sdc_cfg_t cfg_q;

	// Parallel pass-through has top priority; a serial event overrides
	// values latched by the parallel strobe. Any other cycle holds.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= SDC_CFG_RST;
		end else begin
			case (mode_d)
				SDC_MODE_PAR: begin
					cfg_q.m <= feedback_divider_pins; // [R4] [R6]
					cfg_q.n <= output_divider_pins; // [R4]
				end
				SDC_MODE_XFER: begin
					if (sclk_rise) begin
						cfg_q <= shift_d; // [R13] [R14] [R20]
					end else if (sload_rise) begin
						cfg_q <= shift_q; // [R11] [R20]
					end
				end
				SDC_MODE_SHIFT: begin
					// Strobe fall or idle: values hold [R5] [R12] [R18]
					cfg_q <= cfg_q;
				end
				default: begin
					cfg_q <= cfg_q;
				end
			endcase
		end
	end

	assign active_cfg = cfg_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_range_ok <= 1'b0;
		end else begin
			lock_range_ok <= (cfg_q.m >= SDC_M_MIN) && (cfg_q.m <= SDC_M_MAX);
		end
	end

	// ********************************************************
	// Dividers
	// ********************************************************
	logic ref_rise;
	logic fb_rise;
	logic fb_div_n;
	logic ref_div_n;

	sdc_half_div #(.W(SDC_HALF_W)) u_ref_div (
		.clk(clk),
		.rst_n(rst_n),
		.clr(divider_reset_in), // [R16]
		.tick(ref_tick),
		.half(SDC_REF_HALF), // [R1]
		.div_q(ref_div_out),
		.div_n_q(ref_div_n),
		.rise_q(ref_rise)
	);

	// Toggling every M edges gives one period per 2M oscillator edges
	sdc_half_div #(.W(SDC_M_W)) u_fb_div (
		.clk(clk),
		.rst_n(rst_n),
		.clr(divider_reset_in), // [R16]
		.tick(osc_tick),
		.half(cfg_q.m), // [R2]
		.div_q(fb_div_out),
		.div_n_q(fb_div_n),
		.rise_q(fb_rise)
	);

	// Both outputs share one divider; every ratio is even, so the halves stay equal
	sdc_half_div #(.W(SDC_HALF_W)) u_out_div (
		.clk(clk),
		.rst_n(rst_n),
		.clr(divider_reset_in), // [R16]
		.tick(osc_tick),
		.half(SDC_OUT_HALF[cfg_q.n]), // [R3] [R9]
		.div_q(synth_out_a),
		.div_n_q(synth_out_a_n),
		.rise_q()
	);

	assign synth_out_b = synth_out_a;
	assign synth_out_b_n = synth_out_a_n;

	// ********************************************************
	// Phase comparison
	// ********************************************************
	// Up on reference edge, down on feedback edge, both clear when both set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_up <= 1'b0;
			pump_dn <= 1'b0;
		end else if (divider_reset_in) begin
			pump_up <= 1'b0;
			pump_dn <= 1'b0;
		end else if ((pump_up | ref_rise) && (pump_dn | fb_rise)) begin
			pump_up <= 1'b0; // [R2]
			pump_dn <= 1'b0;
		end else begin
			pump_up <= pump_up | ref_rise;
			pump_dn <= pump_dn | fb_rise;
		end
	end

	// ********************************************************
	// Test monitor
	// ********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_monitor <= 1'b0;
		end else if (mode_d == SDC_MODE_PAR) begin
			test_monitor <= 1'b0; // [R7]
		end else begin
			case (cfg_q.t)
				SDC_MON_LOW: test_monitor <= 1'b0; // [R15]
				SDC_MON_SDATA: test_monitor <= serial_data; // [R15]
				SDC_MON_FB: test_monitor <= fb_div_out; // [R15]
				SDC_MON_OUT: test_monitor <= synth_out_a; // [R15]
				default: test_monitor <= 1'b0;
			endcase
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_serial_idle;
		parallel_strobe_n && !serial_load && !sload_prev_q;
	endsequence

	sequence s_xfer_rise;
		parallel_strobe_n && serial_load && !sload_prev_q && !sclk_rise;
	endsequence

	chk_par_pass: assert property ( // [R4]
		!parallel_strobe_n |=> cfg_q.m == $past(feedback_divider_pins)
			&& cfg_q.n == $past(output_divider_pins))
		else $error("divider pins not passed through");

	chk_serial_hold: assert property ( // [R18]
		s_serial_idle |=> $stable(cfg_q))
		else $error("loaded values changed while serial idle");

	chk_mon_par_low: assert property ( // [R7]
		!parallel_strobe_n [*2] |=> !test_monitor)
		else $error("monitor not low in parallel mode");

	chk_xfer_copy: assert property ( // [R11]
		s_xfer_rise |=> cfg_q == $past(shift_q))
		else $error("shift register not copied on transfer");

	chk_xfer_fall: assert property ( // [R12]
		(parallel_strobe_n && !serial_load && sload_prev_q)
			|=> $stable(cfg_q))
		else $error("values not held after transfer fall");

	chk_flow_thru: assert property ( // [R13]
		(parallel_strobe_n && serial_load && sclk_rise)
			|=> cfg_q == shift_q)
		else $error("serial data not passed through");

	chk_shift_in: assert property ( // [R10]
		(parallel_strobe_n && sclk_rise) |=>
			shift_q[0] == $past(serial_data)
			&& shift_q[SDC_CFG_W-1:1] == $past(shift_q[SDC_CFG_W-2:0]))
		else $error("serial bit not shifted in");

	chk_mon_sdata: assert property ( // [R15]
		(parallel_strobe_n && cfg_q.t == SDC_MON_SDATA)
			|=> test_monitor == $past(serial_data))
		else $error("monitor not following serial data");

	chk_reset_out: assert property ( // [R16]
		divider_reset_in |=> !synth_out_a && synth_out_a_n
			&& !fb_div_out && !ref_div_out)
		else $error("divider reset not honoured");

	// Pass-through and serial events may still change values under reset
	chk_reset_keep: assert property ( // [R16]
		(divider_reset_in && parallel_strobe_n && !serial_load
			&& !sload_prev_q) |=> $stable(cfg_q))
		else $error("divider reset disturbed loaded values");

endmodule : sdc_config_top

// ===== design/sdc_half_div.sv
// Edge-counting divider with equal high and low halves.
// Assumes tick is a one-cycle pulse per input rising edge, in the clk domain.
`timescale 1ns/1ns
module sdc_half_div #(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic clr,
	input wire logic tick,
	input wire logic [W-1:0] half,
	// Outputs
	output logic div_q,
	output logic div_n_q,
	output logic rise_q
);
	import sdc_pkg::*;

	logic [W-1:0] cnt_q;
	logic [W:0] cnt_next;
	logic wrap;

	if (W < 1) begin : g_chk
		$error("sdc_half_div: width must be at least one");
	end

	assign cnt_next = {1'b0, cnt_q} + (W+1)'(1);
	// A half of zero toggles every edge rather than stalling
	assign wrap = cnt_next >= {1'b0, half};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			div_q <= 1'b0;
			div_n_q <= 1'b1;
			rise_q <= 1'b0;
		end else if (clr) begin
			cnt_q <= '0;
			div_q <= 1'b0;
			div_n_q <= 1'b1;
			rise_q <= 1'b0;
		end else if (tick && wrap) begin
			cnt_q <= '0;
			div_q <= ~div_q;
			div_n_q <= div_q;
			rise_q <= ~div_q;
		end else begin
			cnt_q <= tick ? cnt_next[W-1:0] : cnt_q;
			rise_q <= 1'b0;
		end
	end

endmodule : sdc_half_div

// ===== design/sdc_pkg.sv
// Shared constants and types of the synthesizer divider configuration logic.
// Assumes one 20 MHz clock; all pins arrive synchronous to it.
package sdc_pkg;

	// ********************************************************
	// Field widths
	// ********************************************************
	localparam int SDC_M_W = 9;
	localparam int SDC_N_W = 3;
	localparam int SDC_T_W = 2;
	localparam int SDC_HALF_W = 4;

	// Serial word: select bits first, then output code, then feedback value
	typedef struct packed {
		logic [SDC_T_W-1:0] t;
		logic [SDC_N_W-1:0] n;
		logic [SDC_M_W-1:0] m;
	} sdc_cfg_t;

	localparam int SDC_CFG_W = $bits(sdc_cfg_t);
	localparam sdc_cfg_t SDC_CFG_RST = 14'h0000;

	// ********************************************************
	// Reference path and lock window
	// ********************************************************
	localparam int SDC_REF_DIV = 16;
	localparam logic [SDC_HALF_W-1:0] SDC_REF_HALF =
		SDC_HALF_W'(SDC_REF_DIV / 2);
	localparam logic [SDC_M_W-1:0] SDC_M_MIN = 9'h064;
	localparam logic [SDC_M_W-1:0] SDC_M_MAX = 9'h15E;

	// Output divider: half period in oscillator edges per code (even ratios)
	localparam logic [7:0][SDC_HALF_W-1:0] SDC_OUT_HALF = {
		4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1
	};

	// ********************************************************
	// Monitor selection codes and load modes
	// ********************************************************
	localparam logic [SDC_T_W-1:0] SDC_MON_LOW = 2'h0;
	localparam logic [SDC_T_W-1:0] SDC_MON_SDATA = 2'h1;
	localparam logic [SDC_T_W-1:0] SDC_MON_FB = 2'h2;
	localparam logic [SDC_T_W-1:0] SDC_MON_OUT = 2'h3;

	typedef enum logic [2:0] {
		SDC_MODE_PAR = 3'h1,
		SDC_MODE_SHIFT = 3'h2,
		SDC_MODE_XFER = 3'h4
	} sdc_mode_t;

endpackage : sdc_pkg

// ===== verification/sdc_config_top_tb_top.sv
// Self-checking bench of the divider configuration logic.
// Assumes the host model owns all load pins; bench drives clock sources.
`timescale 1ns/1ns
module sdc_config_top_tb_top;
	import sdc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ref_source_select = 1'b1;
	logic ref_xtal_in, ref_aux_in, osc_in, pump_up, pump_dn, lock_range_ok;
	logic [2:0] src_q = 3'h0;
	logic divider_reset_in = 1'b0;
	logic parallel_strobe_n, serial_clock, serial_data, serial_load;
	logic [8:0] feedback_divider_pins;
	logic [2:0] output_divider_pins;
	logic ref_div_out, fb_div_out, synth_out_a, synth_out_a_n;
	logic synth_out_b, synth_out_b_n, test_monitor;
	sdc_cfg_t active_cfg;
	sdc_mode_t load_mode;
	logic [3:0] obs;
	int n_mismatch = 0, checks_done = 0;
	sdc_cfg_t w1 = {2'h1, 3'h2, 9'h12C}, w2 = {2'h0, 3'h1, 9'h0C8};
	assign obs = {ref_div_out, fb_div_out, synth_out_a, synth_out_b};

	sdc_host_model u_host (.clk, .parallel_strobe_n, .feedback_divider_pins,
		.output_divider_pins, .serial_clock, .serial_data, .serial_load);
	sdc_config_top u_dut (.clk, .rst_n, .parallel_strobe_n,
		.feedback_divider_pins, .output_divider_pins, .serial_clock,
		.serial_data, .serial_load, .ref_source_select, .ref_xtal_in,
		.ref_aux_in, .osc_in, .divider_reset_in, .pump_up, .pump_dn,
		.ref_div_out, .fb_div_out, .synth_out_a, .synth_out_a_n,
		.synth_out_b, .synth_out_b_n, .test_monitor, .active_cfg,
		.load_mode, .lock_range_ok);

	// ****************************************
	// Clock, sources and helpers
	// ****************************************
	always #25 clk = ~clk;
	// Crystal and oscillator toggle every two cycles, auxiliary every four
	always @(negedge clk) src_q <= src_q + 3'h1;
	assign ref_xtal_in = src_q[1];
	assign osc_in = src_q[1];
	assign ref_aux_in = src_q[2];
	task wait_n(input int k);
		repeat (k) @(negedge clk);
	endtask : wait_n
	task automatic chk(input string nm, input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// High time in cycles of one observed output, from a clean rise
	task automatic hi_len(input int i, output int n);
		n = 0;
		while (obs[i] === 1'b1 && n < 3000) begin wait_n(1); n++; end
		n = 0;
		while (obs[i] !== 1'b1 && n < 3000) begin wait_n(1); n++; end
		n = 0;
		while (obs[i] === 1'b1 && n < 3000) begin wait_n(1); n++; end
	endtask : hi_len
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	// ****************************************
	// Scenarios
	// ****************************************
	task t_par;
		wait_n(2);
		chk("pass cfg", active_cfg, {5'h01, 9'h0C8});
		chk("mode", load_mode, SDC_MODE_PAR);
		chk("mon par", test_monitor, 1'b0);
	endtask : t_par
	task t_latch;
		u_host.strobe(1'b1);
		u_host.pins(9'h15E, 3'h5);
		wait_n(3);
		chk("latched", active_cfg[11:0], {3'h1, 9'h0C8});
		u_host.strobe(1'b0);
		wait_n(2);
		chk("repass", active_cfg[11:0], {3'h5, 9'h15E});
		chk("lock top", lock_range_ok, 1'b1);
		u_host.pins(9'h0C8, 3'h1);
		u_host.strobe(1'b1);
	endtask : t_latch
	task t_serial;
		u_host.shift_word(w1);
		wait_n(2);
		chk("no load", active_cfg[11:0], {3'h1, 9'h0C8});
		u_host.load(1'b1);
		wait_n(2);
		chk("xfer", active_cfg, w1);
		chk("mode x", load_mode, SDC_MODE_XFER);
		u_host.load(1'b0);
		u_host.shift_word(w2);
		wait_n(2);
		chk("held", active_cfg, w1);
		u_host.set_data(1'b1);
		wait_n(2);
		chk("mon d1", test_monitor, 1'b1);
		u_host.set_data(1'b0);
		wait_n(2);
		chk("mon d0", test_monitor, 1'b0);
		u_host.set_data(1'b1);
		u_host.strobe(1'b0);
		wait_n(2);
		chk("mon par", test_monitor, 1'b0);
		u_host.strobe(1'b1);
		u_host.set_data(1'b0);
	endtask : t_serial
	task t_transp;
		u_host.load(1'b1);
		wait_n(2);
		chk("xfer2", active_cfg, w2);
		u_host.shift_bit(1'b1);
		wait_n(2);
		chk("flow", active_cfg, {w2[12:0], 1'b1});
		chk("lock out", lock_range_ok, 1'b0);
		u_host.load(1'b0);
		u_host.set_data(1'b1);
		wait_n(2);
		chk("mon 00", test_monitor, 1'b0);
		u_host.set_data(1'b0);
	endtask : t_transp
	task t_div;
		int n;
		u_host.pins(9'h064, 3'h1);
		u_host.strobe(1'b0);
		wait_n(4);
		chk("lock low", lock_range_ok, 1'b1);
		hi_len(3, n);
		chk("ref half", n, 16'd32);
		hi_len(1, n);
		chk("out a half", n, 16'd8);
		hi_len(0, n);
		chk("out b half", n, 16'd8);
		hi_len(2, n);
		chk("fb half", n, 16'd400);
		// Reference edges outnumber feedback edges, so up is pending
		chk("pump", {pump_up, pump_dn}, 2'h2);
		ref_source_select = 1'b0;
		hi_len(3, n);
		chk("aux half", n, 16'd64);
		ref_source_select = 1'b1;
	endtask : t_div
	task t_mr;
		// Strobe high first so the kept values are latched, not passed
		u_host.strobe(1'b1);
		@(negedge clk) divider_reset_in = 1'b1;
		wait_n(3);
		chk("mr pump", {pump_up, pump_dn}, 2'h0);
		chk("mr ref", ref_div_out, 1'b0);
		chk("mr out", {synth_out_a, synth_out_b, fb_div_out}, 0);
		chk("mr out n", {synth_out_a_n, synth_out_b_n}, 2'h3);
		chk("mr keep", active_cfg[11:0], {3'h1, 9'h064});
		divider_reset_in = 1'b0;
	endtask : t_mr

	initial begin
		wait_n(6);
		rst_n = 1'b1;
		t_par();
		t_latch();
		t_serial();
		t_transp();
		t_div();
		t_mr();
		report_and_stop();
	end
	// Whole run is under 1700 cycles; give it 30000 cycles
	initial begin
		#1500000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : sdc_config_top_tb_top

// ===== verification/sdc_host_model.sv
// Host controller model: drives the parallel pins and the serial link.
// Assumes clk is the device clock; every pin changes on its falling edge.
`timescale 1ns/1ns
module sdc_host_model (
	// Clock
	input wire logic clk,
	// Parallel pins
	output logic parallel_strobe_n,
	output logic [8:0] feedback_divider_pins,
	output logic [2:0] output_divider_pins,
	// Serial link
	output logic serial_clock,
	output logic serial_data,
	output logic serial_load
);
	import sdc_pkg::*;
	// Pins held from time zero so pass-through gives power-up defaults
	initial begin
		parallel_strobe_n = 1'b0;
		feedback_divider_pins = 9'h0C8;
		output_divider_pins = 3'h1;
		serial_clock = 1'b0;
		serial_data = 1'b0;
		serial_load = 1'b0;
	end
	task pins(input logic [8:0] m, input logic [2:0] n);
		@(negedge clk);
		feedback_divider_pins = m;
		output_divider_pins = n;
	endtask : pins
	task strobe(input logic v);
		@(negedge clk);
		parallel_strobe_n = v;
	endtask : strobe
	task load(input logic v);
		@(negedge clk);
		serial_load = v;
	endtask : load
	task set_data(input logic b);
		@(negedge clk);
		serial_data = b;
	endtask : set_data
	// Clock stands low between bits; data drops to its pulldown level
	task shift_bit(input logic b);
		@(negedge clk);
		serial_data = b;
		serial_clock = 1'b1;
		@(negedge clk);
		serial_clock = 1'b0;
		serial_data = 1'b0;
	endtask : shift_bit
	task shift_word(input sdc_cfg_t w);
		for (int i = 13; i >= 0; i--) shift_bit(w[i]);
	endtask : shift_word
endmodule : sdc_host_model
